//--- rtl/cccd_pkg.sv
// Shared constants for the calendar clock control and date block.
package cccd_pkg;

	// Clock rate and register port geometry.
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;

	// Register offsets (byte addresses).
	localparam logic [ADDR_W-1:0] CALENDAR_CONTROL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] TIME_VALUE_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] CALENDAR_DATE_VALUE_OFS = 4'h8;
	localparam logic [ADDR_W-1:0] ALARM_DATE_VALUE_OFS = 4'hC;

	// Control register fields.
	localparam int unsigned CTL_ON_BIT = 15;
	localparam int unsigned CTL_TSEL_LSB = 9;
	localparam int unsigned CTL_OSEL_LSB = 7;
	localparam int unsigned CTL_RUN_BIT = 6;
	localparam int unsigned CTL_UNLOCK_BIT = 3;
	localparam int unsigned CTL_HAZARD_BIT = 2;
	localparam int unsigned CTL_HALF_BIT = 1;
	localparam int unsigned CTL_OE_BIT = 0;

	// Tick source and pin output codes.
	localparam logic [1:0] TSEL_INTERNAL = 2'h0;
	localparam logic [1:0] TSEL_EXTERNAL = 2'h1;
	localparam logic [1:0] OSEL_ALARM = 2'h0;
	localparam logic [1:0] OSEL_SECOND = 2'h1;
	localparam logic [1:0] OSEL_TICK = 2'h2;

	// Time value register fields.
	localparam int unsigned SEC_LSB = 8;
	localparam int unsigned SEC_W = 7;
	localparam int unsigned MIN_LSB = 16;
	localparam int unsigned MIN_W = 7;
	localparam int unsigned HOUR_LSB = 24;
	localparam int unsigned HOUR_W = 6;

	// Date register fields.
	localparam int unsigned YEAR_LSB = 24;
	localparam int unsigned YEAR_W = 8;
	localparam int unsigned MON_LSB = 16;
	localparam int unsigned MON_W = 5;
	localparam int unsigned DAY_LSB = 8;
	localparam int unsigned DAY_W = 6;
	localparam int unsigned WDAY_LSB = 0;
	localparam int unsigned WDAY_W = 3;

	// BCD limits of the counting fields.
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] MIN_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST = 8'h23;
	localparam logic [7:0] MON_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST = 8'h99;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [2:0] WDAY_LAST = 3'h6;

	// Reset values.
	localparam logic [7:0] YEAR_RST = 8'h00;
	localparam logic [7:0] MON_RST = 8'h01;
	localparam logic [7:0] DAY_RST = 8'h01;
	localparam logic [2:0] WDAY_RST = 3'h0;

	// Prescaler: ticks per second for each source, and the carry window.
	localparam int unsigned PRESC_W = 15;
	localparam logic [PRESC_W-1:0] EXT_LAST = 15'h7FFF;
	localparam logic [PRESC_W-1:0] INT_LAST = 15'h7CFF;
	localparam logic [PRESC_W-1:0] HAZARD_TICKS = 15'h0020;

	// Tick running watchdog: no tick for this long means the clock stopped.
	localparam int unsigned TICK_TIMEOUT_NS = 100000;
	localparam int unsigned TICK_TIMEOUT_CYC = (TICK_TIMEOUT_NS / 1000) * (CLK_HZ / 1000000);
	localparam int unsigned TMO_W = 12;

endpackage

//--- rtl/cccd_prescaler.sv
// Tick source selection and one-second prescaler for the calendar block.
`timescale 1ns/1ns
module cccd_prescaler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [1:0] tick_select,
	// Tick sources
	input wire logic tick_external,
	input wire logic tick_internal,
	// Status
	output logic tick_level,
	output logic second_pulse,
	output logic half_second,
	output logic hazard,
	output logic running
);

	logic [cccd_pkg::PRESC_W-1:0] count_reg, count_next;
	logic [cccd_pkg::TMO_W-1:0] tmo_reg, tmo_next;
	logic prev_reg, prev_next;
	logic sec_reg, sec_next;
	logic [cccd_pkg::PRESC_W-1:0] last;
	logic tick_edge;

	always_comb begin
		tick_level = 1'b0;
		last = cccd_pkg::INT_LAST;
		case (tick_select) // [RULE_01]
			cccd_pkg::TSEL_EXTERNAL: begin
				tick_level = tick_external;
				last = cccd_pkg::EXT_LAST;
			end
			cccd_pkg::TSEL_INTERNAL: begin
				tick_level = tick_internal;
			end
			default: begin
				tick_level = 1'b0;
			end
		endcase
		tick_edge = tick_level && !prev_reg;
		prev_next = tick_level;
		count_next = count_reg;
		sec_next = 1'b0;
		if (restart) begin
			count_next = '0;
		end else if (run && tick_edge) begin
			if (count_reg >= last) begin
				count_next = '0;
				sec_next = 1'b1;
			end else begin
				count_next = count_reg + 15'h0001;
			end
		end
		if (tick_edge) begin
			tmo_next = cccd_pkg::TMO_W'(cccd_pkg::TICK_TIMEOUT_CYC);
		end else if (tmo_reg != '0) begin
			tmo_next = tmo_reg - 12'h001;
		end else begin
			tmo_next = tmo_reg;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
			tmo_reg <= '0;
			prev_reg <= 1'b0;
			sec_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tmo_reg <= tmo_next;
			prev_reg <= prev_next;
			sec_reg <= sec_next;
		end
	end

	assign second_pulse = sec_reg;
	assign half_second = (count_reg > (last >> 1)); // [RULE_11]
	assign hazard = (count_reg >= (last - cccd_pkg::HAZARD_TICKS)) || sec_reg; // [RULE_09]
	assign running = (tmo_reg != '0); // [RULE_05]

endmodule

//--- rtl/cccd_calendar.sv
// Calendar clock: control register, time and date values, alarm date and output pin.
// Functional notes
// RULE_01: Tick source select 01 picks the 32.768 kHz oscillator, 00 the internal one.
// RULE_02: Software should rewrite seconds after changing tick source to reset prescalers.
// RULE_03: Pin select 10 gives tick clock, 01 seconds clock, 00 alarm pulse.
// RULE_04: Selected signal reaches the pin only while output enable bit 0 is set.
// RULE_05: Status bit 6 reads 1 while the tick clock runs, else 0.
// RULE_06: Write unlock bit 3 permits value register writes; clear blocks them. Alarm date writes are accepted regardless of it.
// RULE_07: Unlock bit can be set only while the system unlock sequence is open.
// RULE_08: The on bit is writable only while the unlock bit is 1.
// RULE_09: Hazard bit 2 reads 1 when values may ripple during a read.
// RULE_10: While hazard is set software reads twice and trusts only matching reads.
// RULE_11: Half-second flag bit 1 reads 1 in the second half of each second.
// RULE_12: Writing the seconds field of the time register clears the half-second flag.
// RULE_13: Control register is reset only by power-on reset.
// RULE_14: Date holds year tens in bits 31-28, ones in bits 27-24.
// RULE_15: Month tens is bit 20, month ones bits 19-16.
// RULE_16: Day tens in bits 13-12, day ones in bits 11-8.
// RULE_17: Weekday in bits 2-0, values 0 to 6; unused date bits read zero.
// RULE_18: Date register accepts writes only while unlocked.
// RULE_19: Alarm date holds month, day, weekday at date positions; top byte reads zero.
// RULE_20: Each second time and date advance with BCD carry and calendar rollover.
// RULE_21: Date matching alarm date raises the alarm event and alarm pin pulse.
`timescale 1ns/1ns
module cccd_calendar (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sys_reset,
	// Register port
	input wire logic [cccd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cccd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [cccd_pkg::DATA_W-1:0] reg_rdata,
	// System unlock sequence and tick sources
	input wire logic write_seq_enable,
	input wire logic tick_external,
	input wire logic tick_internal,
	// Pin and alarm event
	output logic calendar_pin,
	output logic alarm_irq
);

	// Two-digit BCD increment: returns {wrap, next}; wraps from last to first.
	function automatic logic [8:0] bcd2_inc(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		if (v >= last) begin
			bcd2_inc = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			bcd2_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd2_inc = {1'b0, v + 8'h01};
		end
	endfunction

	// Leap year test on a two-digit BCD year.
	function automatic logic is_leap(input logic [7:0] y);
		if (y[4] == 1'b0) begin
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end else begin
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end
	endfunction

	// Last day of a BCD month.
	function automatic logic [7:0] month_last_day(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02: begin
				month_last_day = is_leap(y) ? 8'h29 : 8'h28;
			end
			8'h04, 8'h06, 8'h09, 8'h11: begin
				month_last_day = 8'h30;
			end
			default: begin
				month_last_day = 8'h31;
			end
		endcase
	endfunction

	// Control state.
	logic on_reg, on_next;
	logic [1:0] tsel_reg, tsel_next;
	logic [1:0] osel_reg, osel_next;
	logic unlock_reg, unlock_next;
	logic oe_reg, oe_next;

	// Time and date values.
	logic [7:0] sec_reg, sec_next;
	logic [7:0] min_reg, min_next;
	logic [7:0] hour_reg, hour_next;
	logic [7:0] year_reg, year_next;
	logic [7:0] month_reg, month_next;
	logic [7:0] day_reg, day_next;
	logic [2:0] wday_reg, wday_next;

	// Alarm date.
	logic [7:0] al_month_reg, al_month_next;
	logic [7:0] al_day_reg, al_day_next;
	logic [2:0] al_wday_reg, al_wday_next;

	// Outputs and alarm edge state.
	logic [cccd_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic pin_reg, pin_next;
	logic irq_reg, irq_next;
	logic match_reg, match_next;

	// Prescaler status.
	logic tick_level, second_pulse, half_second, hazard, running;

	// Decode and step helpers.
	logic wr_ctl, wr_time, wr_date, wr_alarm;
	logic [8:0] s_step, m_step, h_step, d_step, mo_step, y_step;
	logic date_match, alarm_evt, pin_sel;
	logic [cccd_pkg::DATA_W-1:0] ctl_word, time_word, date_word, alarm_word;

	assign wr_ctl = reg_write && (reg_addr == cccd_pkg::CALENDAR_CONTROL_OFS);
	assign wr_time = reg_write && (reg_addr == cccd_pkg::TIME_VALUE_OFS) && unlock_reg; // [RULE_06]
	assign wr_date = reg_write && (reg_addr == cccd_pkg::CALENDAR_DATE_VALUE_OFS)
		&& unlock_reg; // [RULE_18]
	assign wr_alarm = reg_write && (reg_addr == cccd_pkg::ALARM_DATE_VALUE_OFS);

	// Restarting on a seconds write also clears the half-second flag.
	cccd_prescaler u_cccd_prescaler (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(on_reg),
		.restart(sys_reset || wr_time), // [RULE_12]
		.tick_select(tsel_reg),
		.tick_external(tick_external),
		.tick_internal(tick_internal),
		.tick_level(tick_level),
		.second_pulse(second_pulse),
		.half_second(half_second),
		.hazard(hazard),
		.running(running)
	);

	assign s_step = bcd2_inc(sec_reg, cccd_pkg::SEC_LAST, cccd_pkg::BCD_ZERO); // [RULE_20]
	assign m_step = bcd2_inc(min_reg, cccd_pkg::MIN_LAST, cccd_pkg::BCD_ZERO);
	assign h_step = bcd2_inc(hour_reg, cccd_pkg::HOUR_LAST, cccd_pkg::BCD_ZERO);
	assign d_step = bcd2_inc(day_reg, month_last_day(month_reg, year_reg), cccd_pkg::BCD_ONE);
	assign mo_step = bcd2_inc(month_reg, cccd_pkg::MON_LAST, cccd_pkg::BCD_ONE);
	assign y_step = bcd2_inc(year_reg, cccd_pkg::YEAR_LAST, cccd_pkg::BCD_ZERO);

	assign date_match = (month_reg == al_month_reg) && (day_reg == al_day_reg)
		&& (wday_reg == al_wday_reg);
	assign alarm_evt = on_reg && date_match && !match_reg; // [RULE_21]

	always_comb begin
		ctl_word = '0;
		ctl_word[cccd_pkg::CTL_ON_BIT] = on_reg;
		ctl_word[cccd_pkg::CTL_TSEL_LSB +: 2] = tsel_reg;
		ctl_word[cccd_pkg::CTL_OSEL_LSB +: 2] = osel_reg;
		ctl_word[cccd_pkg::CTL_RUN_BIT] = running; // [RULE_05]
		ctl_word[cccd_pkg::CTL_UNLOCK_BIT] = unlock_reg;
		ctl_word[cccd_pkg::CTL_HAZARD_BIT] = hazard; // [RULE_09]
		ctl_word[cccd_pkg::CTL_HALF_BIT] = half_second; // [RULE_11]
		ctl_word[cccd_pkg::CTL_OE_BIT] = oe_reg;
		time_word = '0;
		time_word[cccd_pkg::SEC_LSB +: cccd_pkg::SEC_W] = sec_reg[cccd_pkg::SEC_W-1:0];
		time_word[cccd_pkg::MIN_LSB +: cccd_pkg::MIN_W] = min_reg[cccd_pkg::MIN_W-1:0];
		time_word[cccd_pkg::HOUR_LSB +: cccd_pkg::HOUR_W] = hour_reg[cccd_pkg::HOUR_W-1:0];
		date_word = '0; // [RULE_17]
		date_word[cccd_pkg::YEAR_LSB +: cccd_pkg::YEAR_W] = year_reg; // [RULE_14]
		date_word[cccd_pkg::MON_LSB +: cccd_pkg::MON_W] = month_reg[cccd_pkg::MON_W-1:0]; // [RULE_15]
		date_word[cccd_pkg::DAY_LSB +: cccd_pkg::DAY_W] = day_reg[cccd_pkg::DAY_W-1:0]; // [RULE_16]
		date_word[cccd_pkg::WDAY_LSB +: cccd_pkg::WDAY_W] = wday_reg; // [RULE_17]
		alarm_word = '0; // [RULE_19]
		alarm_word[cccd_pkg::MON_LSB +: cccd_pkg::MON_W] = al_month_reg[cccd_pkg::MON_W-1:0];
		alarm_word[cccd_pkg::DAY_LSB +: cccd_pkg::DAY_W] = al_day_reg[cccd_pkg::DAY_W-1:0];
		alarm_word[cccd_pkg::WDAY_LSB +: cccd_pkg::WDAY_W] = al_wday_reg;
	end

	// Control register next state.
	always_comb begin
		on_next = on_reg;
		tsel_next = tsel_reg;
		osel_next = osel_reg;
		unlock_next = unlock_reg;
		oe_next = oe_reg;
		if (wr_ctl) begin
			tsel_next = reg_wdata[cccd_pkg::CTL_TSEL_LSB +: 2];
			osel_next = reg_wdata[cccd_pkg::CTL_OSEL_LSB +: 2];
			oe_next = reg_wdata[cccd_pkg::CTL_OE_BIT];
			if (!reg_wdata[cccd_pkg::CTL_UNLOCK_BIT] || write_seq_enable) begin
				unlock_next = reg_wdata[cccd_pkg::CTL_UNLOCK_BIT]; // [RULE_07]
			end
			if (unlock_reg) begin
				on_next = reg_wdata[cccd_pkg::CTL_ON_BIT]; // [RULE_08]
			end
		end
	end

	// Only power-on reset touches the control register.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin // [RULE_13]
			on_reg <= 1'b0;
			tsel_reg <= cccd_pkg::TSEL_INTERNAL;
			osel_reg <= cccd_pkg::OSEL_ALARM;
			unlock_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			on_reg <= on_next;
			tsel_reg <= tsel_next;
			osel_reg <= osel_next;
			unlock_reg <= unlock_next;
			oe_reg <= oe_next;
		end
	end

	// Value register next state: software writes win over the second tick.
	always_comb begin
		sec_next = sec_reg;
		min_next = min_reg;
		hour_next = hour_reg;
		year_next = year_reg;
		month_next = month_reg;
		day_next = day_reg;
		wday_next = wday_reg;
		al_month_next = al_month_reg;
		al_day_next = al_day_reg;
		al_wday_next = al_wday_reg;
		if (second_pulse && on_reg) begin // [RULE_20]
			sec_next = s_step[7:0];
			if (s_step[8]) begin
				min_next = m_step[7:0];
				if (m_step[8]) begin
					hour_next = h_step[7:0];
					if (h_step[8]) begin
						day_next = d_step[7:0];
						wday_next = (wday_reg >= cccd_pkg::WDAY_LAST) ? 3'h0 : wday_reg + 3'h1;
						if (d_step[8]) begin
							month_next = mo_step[7:0];
							if (mo_step[8]) begin
								year_next = y_step[7:0];
							end
						end
					end
				end
			end
		end
		if (wr_time) begin // [RULE_06]
			sec_next = {1'b0, reg_wdata[cccd_pkg::SEC_LSB +: cccd_pkg::SEC_W]};
			min_next = {1'b0, reg_wdata[cccd_pkg::MIN_LSB +: cccd_pkg::MIN_W]};
			hour_next = {2'b00, reg_wdata[cccd_pkg::HOUR_LSB +: cccd_pkg::HOUR_W]};
		end
		if (wr_date) begin // [RULE_18]
			year_next = reg_wdata[cccd_pkg::YEAR_LSB +: cccd_pkg::YEAR_W];
			month_next = {3'b000, reg_wdata[cccd_pkg::MON_LSB +: cccd_pkg::MON_W]};
			day_next = {2'b00, reg_wdata[cccd_pkg::DAY_LSB +: cccd_pkg::DAY_W]};
			wday_next = reg_wdata[cccd_pkg::WDAY_LSB +: cccd_pkg::WDAY_W];
		end
		if (wr_alarm) begin // [RULE_19]
			al_month_next = {3'b000, reg_wdata[cccd_pkg::MON_LSB +: cccd_pkg::MON_W]};
			al_day_next = {2'b00, reg_wdata[cccd_pkg::DAY_LSB +: cccd_pkg::DAY_W]};
			al_wday_next = reg_wdata[cccd_pkg::WDAY_LSB +: cccd_pkg::WDAY_W];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sec_reg <= cccd_pkg::BCD_ZERO;
			min_reg <= cccd_pkg::BCD_ZERO;
			hour_reg <= cccd_pkg::BCD_ZERO;
			year_reg <= cccd_pkg::YEAR_RST;
			month_reg <= cccd_pkg::MON_RST;
			day_reg <= cccd_pkg::DAY_RST;
			wday_reg <= cccd_pkg::WDAY_RST;
			al_month_reg <= cccd_pkg::MON_RST;
			al_day_reg <= cccd_pkg::DAY_RST;
			al_wday_reg <= cccd_pkg::WDAY_RST;
		end else begin
			sec_reg <= sec_next;
			min_reg <= min_next;
			hour_reg <= hour_next;
			year_reg <= year_next;
			month_reg <= month_next;
			day_reg <= day_next;
			wday_reg <= wday_next;
			al_month_reg <= al_month_next;
			al_day_reg <= al_day_next;
			al_wday_reg <= al_wday_next;
		end
	end

	// Read data, pin and alarm event next state.
	always_comb begin
		rdata_next = '0;
		if (reg_read) begin
			case (reg_addr)
				cccd_pkg::CALENDAR_CONTROL_OFS: begin
					rdata_next = ctl_word;
				end
				cccd_pkg::TIME_VALUE_OFS: begin
					rdata_next = time_word;
				end
				cccd_pkg::CALENDAR_DATE_VALUE_OFS: begin
					rdata_next = date_word;
				end
				cccd_pkg::ALARM_DATE_VALUE_OFS: begin
					rdata_next = alarm_word;
				end
				default: begin
					rdata_next = '0;
				end
			endcase
		end
		case (osel_reg) // [RULE_03]
			cccd_pkg::OSEL_TICK: begin
				pin_sel = tick_level;
			end
			cccd_pkg::OSEL_SECOND: begin
				pin_sel = !half_second;
			end
			cccd_pkg::OSEL_ALARM: begin
				pin_sel = alarm_evt;
			end
			default: begin
				pin_sel = 1'b0;
			end
		endcase
		pin_next = oe_reg && pin_sel; // [RULE_04]
		irq_next = alarm_evt; // [RULE_21]
		match_next = on_reg && date_match;
		if (sys_reset) begin
			rdata_next = '0;
			pin_next = 1'b0;
			irq_next = 1'b0;
			match_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_reg <= '0;
			pin_reg <= 1'b0;
			irq_reg <= 1'b0;
			match_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			pin_reg <= pin_next;
			irq_reg <= irq_next;
			match_reg <= match_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign calendar_pin = pin_reg;
	assign alarm_irq = irq_reg;

endmodule

//--- sim/cccd_calendar_sva.sv
// Concurrent checks on the calendar block's register port, pin and alarm event.
`timescale 1ns/1ns
module cccd_calendar_sva (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sys_reset,
	// Register port
	input wire logic [cccd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cccd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [cccd_pkg::DATA_W-1:0] reg_rdata,
	// Unlock sequence and tick sources
	input wire logic write_seq_enable,
	input wire logic tick_external,
	input wire logic tick_internal,
	// Pin and alarm event
	input wire logic calendar_pin,
	input wire logic alarm_irq
);
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	logic ctl_hit;
	logic rd_ctl;
	assign ctl_hit = reg_write && (reg_addr == cccd_pkg::CALENDAR_CONTROL_OFS);
	assign rd_ctl = reg_read && !sys_reset && (reg_addr == cccd_pkg::CALENDAR_CONTROL_OFS);
	// Shadow of the writable control bits, gated the way software expects.
	always_comb begin
		ctl_next = ctl_reg;
		if (ctl_hit) begin
			ctl_next[10:7] = reg_wdata[10:7];
			ctl_next[0] = reg_wdata[0];
			if (!reg_wdata[3] || write_seq_enable) begin
				ctl_next[3] = reg_wdata[3];
			end
			if (ctl_reg[3]) begin
				ctl_next[15] = reg_wdata[15];
			end
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctl_reg <= 16'h0000;
		end else begin
			ctl_reg <= ctl_next;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_ctl_lock;
		rd_ctl |=> reg_rdata[15] == ctl_reg[15] && reg_rdata[3] == ctl_reg[3];
	endproperty
	a_ctl_lock: assert property (p_ctl_lock)
		else $error("on or unlock bit gating wrong");
	property p_ctl_fields;
		rd_ctl |=> reg_rdata[10:7] == ctl_reg[10:7] && reg_rdata[0] == ctl_reg[0]
			&& reg_rdata[5:4] == 2'h0;
	endproperty
	a_ctl_fields: assert property (p_ctl_fields)
		else $error("control fields read back wrong");
	property p_date_unused;
		reg_read && !sys_reset && reg_addr == cccd_pkg::CALENDAR_DATE_VALUE_OFS
			|=> (reg_rdata & 32'h00E0C0F8) == 32'h00000000;
	endproperty
	a_date_unused: assert property (p_date_unused)
		else $error("date unused bits not zero");
	property p_alarm_unused;
		reg_read && !sys_reset && reg_addr == cccd_pkg::ALARM_DATE_VALUE_OFS
			|=> (reg_rdata & 32'hFFE0C0F8) == 32'h00000000;
	endproperty
	a_alarm_unused: assert property (p_alarm_unused)
		else $error("alarm date unused bits set");
	property p_pin_off;
		!ctl_reg[0] |=> !calendar_pin;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("pin active with output disabled");
	property p_irq_needs_on;
		!ctl_reg[15] [*3] |=> !alarm_irq;
	endproperty
	a_irq_needs_on: assert property (p_irq_needs_on)
		else $error("alarm while block off");
	property p_irq_pulse;
		alarm_irq |=> !alarm_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("alarm event longer than one cycle");
	property p_irq_pin;
		alarm_irq && $past(ctl_reg[0]) && $past(ctl_reg[8:7]) == 2'h0 |-> calendar_pin;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("alarm pulse missing on pin");
endmodule

//--- sim/cccd_calendar_bench.sv
// Self-checking bench for the calendar clock control and date block.
`timescale 1ns/1ns
module cccd_calendar_bench;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] NORUN = 32'hFFFFFFBF;
	localparam int LIMIT = 50000;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic sys_reset = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic write_seq_enable = 1'b0;
	logic tick_external = 1'b0;
	logic tick_internal = 1'b0;
	logic calendar_pin;
	logic alarm_irq;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	cccd_calendar u_cccd_calendar (
		.clk_sys(clk_sys), .reset(reset), .sys_reset(sys_reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .write_seq_enable(write_seq_enable),
		.tick_external(tick_external), .tick_internal(tick_internal), .calendar_pin(calendar_pin),
		.alarm_irq(alarm_irq)
	);
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// Both oscillators give one rising edge every two system cycles.
	always @(posedge clk_sys) begin
		tick_external <= ~tick_external;
		tick_internal <= ~tick_internal;
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count = bad_count + 1;
			test_done();
		end
	end
	task automatic test_done;
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp,
		input string nm);
		logic [31:0] d;
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge clk_sys);
		chk(nm, d & m, exp);
	endtask
	// Counts pin and alarm highs over n cycles.
	task automatic watch(input int n, input int pin_exp, input int irq_exp);
		int pins;
		int irqs;
		pins = 0;
		irqs = 0;
		repeat (n) begin
			#1;
			if (calendar_pin === 1'b1) pins++;
			if (alarm_irq === 1'b1) irqs++;
			@(posedge clk_sys);
		end
		chk("pin highs", 32'(pins), 32'(pin_exp));
		chk("alarm events", 32'(irqs), 32'(irq_exp));
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, NORUN, 32'h0, "control");
		rdc(cccd_pkg::TIME_VALUE_OFS, ALL, 32'h0, "time");
		rdc(cccd_pkg::CALENDAR_DATE_VALUE_OFS, ALL, 32'h00010100, "date");
		rdc(cccd_pkg::ALARM_DATE_VALUE_OFS, ALL, 32'h00010100, "alarm date");
		rdc(4'h2, ALL, 32'h0, "unmapped");
		$display("test reset values done");
		wr(cccd_pkg::CALENDAR_DATE_VALUE_OFS, 32'h25123106);
		rdc(cccd_pkg::CALENDAR_DATE_VALUE_OFS, ALL, 32'h00010100, "locked date");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008008);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, NORUN, 32'h0, "unlock refused");
		write_seq_enable <= 1'b1;
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008008);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, NORUN, 32'h00000008, "on refused");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008008);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, NORUN, 32'h00008008, "on set");
		$display("test unlock done");
		wr(cccd_pkg::CALENDAR_DATE_VALUE_OFS, 32'h25F2F1FE);
		rdc(cccd_pkg::CALENDAR_DATE_VALUE_OFS, ALL, 32'h25123106, "date");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008000);
		wr(cccd_pkg::CALENDAR_DATE_VALUE_OFS, 32'h00010100);
		rdc(cccd_pkg::CALENDAR_DATE_VALUE_OFS, ALL, 32'h25123106, "relocked");
		$display("test date done");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008001);
		wr(cccd_pkg::ALARM_DATE_VALUE_OFS, 32'hFF123106);
		watch(6, 1, 1);
		rdc(cccd_pkg::ALARM_DATE_VALUE_OFS, ALL, 32'h00123106, "alarm date");
		wr(cccd_pkg::ALARM_DATE_VALUE_OFS, 32'h00123105);
		watch(6, 0, 0);
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008000);
		wr(cccd_pkg::ALARM_DATE_VALUE_OFS, 32'h00123106);
		watch(6, 0, 1);
		$display("test alarm done");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008289);
		wr(cccd_pkg::TIME_VALUE_OFS, 32'h0);
		repeat (32868) @(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, ALL, 32'h000082CB, "half set");
		watch(2, 0, 0);
		wr(cccd_pkg::TIME_VALUE_OFS, 32'h0);
		@(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, ALL, 32'h000082C9, "half cleared");
		watch(2, 2, 0);
		rdc(cccd_pkg::TIME_VALUE_OFS, ALL, 32'h0, "time read once");
		rdc(cccd_pkg::TIME_VALUE_OFS, ALL, 32'h0, "time read twice");
		$display("test half second done");
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008309);
		watch(8, 4, 0);
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008389);
		watch(8, 0, 0);
		wr(cccd_pkg::CALENDAR_CONTROL_OFS, 32'h00008489);
		repeat (2600) @(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, ALL, 32'h00008489, "tick stopped");
		$display("test pin and tick done");
		sys_reset <= 1'b1;
		@(posedge clk_sys);
		sys_reset <= 1'b0;
		@(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, ALL, 32'h00008489, "kept control");
		rdc(cccd_pkg::CALENDAR_DATE_VALUE_OFS, ALL, 32'h25123106, "kept date");
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rdc(cccd_pkg::CALENDAR_CONTROL_OFS, NORUN, 32'h0, "power-on control");
		$display("test resets done");
		test_done();
	end
endmodule
bind cccd_calendar cccd_calendar_sva u_cccd_calendar_sva (
	.clk_sys(clk_sys), .reset(reset), .sys_reset(sys_reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.write_seq_enable(write_seq_enable), .tick_external(tick_external),
	.tick_internal(tick_internal), .calendar_pin(calendar_pin), .alarm_irq(alarm_irq)
);
